// [hdl/osa_params.svh]
// What this block does
// - run indicator goes to selected port 0..7
// - run invert bit flips run indicator level
// - settings volatile, defaults restored at power-on
// - program start restores factory default settings
// - alarm clear restores factory default settings
// - read-only status word, range 0 to 63
// - status bits: run,move,end,step,home,brake
// - moving bit set when motion command begins
// - step sync indicator goes to selected port unless run or end selects the same port
// - step invert bit flips step sync level
// - end indicator also assignable to ports 0..7
//
// Purpose: offsets, field positions and factory defaults of the output assignment block
// Assumes: byte addresses on a 32-bit AHB-Lite bus, one word per register
// Notes: settings registers are write-only and read back as zero
`ifndef OSA_PARAMS_SVH
`define OSA_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OSA_RUN_SEL_OFF 8'h00
`define OSA_RUN_INV_OFF 8'h04
`define OSA_STEP_SEL_OFF 8'h08
`define OSA_STEP_INV_OFF 8'h0C
`define OSA_END_SEL_OFF 8'h10
`define OSA_END_INV_OFF 8'h14
`define OSA_STATUS_OFF 8'h18
`define OSA_GENOUT_OFF 8'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define OSA_SEL_MSB 2
`define OSA_INV_BIT 0
`define OSA_ST_RUN 0
`define OSA_ST_MOVE 1
`define OSA_ST_END 2
`define OSA_ST_STEP 3
`define OSA_ST_HOME 4
`define OSA_ST_BRAKE 5

// ----------------------------------------
// factory defaults
// ----------------------------------------
`define OSA_RUN_SEL_DEF 3'h0
`define OSA_STEP_SEL_DEF 3'h1
`define OSA_END_SEL_DEF 3'h2
`define OSA_INV_DEF 1'h0
`define OSA_GENOUT_DEF 8'h00

`endif

// [hdl/osa_pkg.sv]
// Purpose: shared types of the output assignment block
// Assumes: eight general output ports
// Notes: constants live in osa_params.svh
package osa_pkg;
	typedef logic [2:0] osa_sel_t;
	typedef logic [5:0] osa_stat_t;
	typedef logic [7:0] osa_port_t;
endpackage : osa_pkg

// [hdl/osa_top.sv]
// Purpose: routes run, end and step sync indicators to general output ports
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes: unassigned ports follow the general output register
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "osa_params.svh"

module osa_top #(
	parameter int NPORT = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic running,
	input wire logic moving,
	input wire logic motion_start,
	input wire logic end_indicator,
	input wire logic step_sync_signal,
	input wire logic home_indicator,
	input wire logic brake_control_output,
	input wire logic run_command,
	input wire logic start_input,
	input wire logic alarm_clear_command,
	input wire logic alarm_clear_input,
	output osa_pkg::osa_port_t gen_out,
	output osa_pkg::osa_stat_t output_status_word
);
	import osa_pkg::*;

	// ----------------------------------------
	// elaboration check
	// ----------------------------------------
	// port selects are three bits wide, so exactly eight ports
	if (NPORT != 8) begin : g_bad_nport
		$error("osa_top: NPORT must be 8");
	end

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	logic wr_q;
	logic [7:0] wa_q;
	logic restore;
	logic wr_en;
	osa_sel_t run_sel_q;
	osa_sel_t step_sel_q;
	osa_sel_t end_sel_q;
	logic run_inv_q;
	logic step_inv_q;
	logic end_inv_q;
	osa_port_t genout_q;
	osa_stat_t stat_q;
	logic [31:0] rdata_q;
	logic addr_ok;

	assign addr_ok = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;
	// a restore event in the same cycle as a write overrides it
	assign restore = run_command | start_input | alarm_clear_command | alarm_clear_input;
	assign wr_en = wr_q && !restore;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
		end else begin
			wr_q <= addr_ok && hwrite;
			wa_q <= haddr[7:0];
		end
	end

	// settings are write-only; only status and general output read back
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 32'h00000000;
		end else if (addr_ok && !hwrite) begin
			if (hit(haddr[7:0], `OSA_STATUS_OFF)) begin
				rdata_q <= {26'h0, stat_q};
			end else if (hit(haddr[7:0], `OSA_GENOUT_OFF)) begin
				rdata_q <= {24'h000000, genout_q};
			end else begin
				rdata_q <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// assignment settings
	// ----------------------------------------
	// volatile flops: power-on reset and restore events load defaults
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_sel_q <= `OSA_RUN_SEL_DEF;
		end else if (restore) begin
			run_sel_q <= `OSA_RUN_SEL_DEF;
		end else if (wr_en && hit(wa_q, `OSA_RUN_SEL_OFF)) begin
			run_sel_q <= hwdata[`OSA_SEL_MSB:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_inv_q <= `OSA_INV_DEF;
		end else if (restore) begin
			run_inv_q <= `OSA_INV_DEF;
		end else if (wr_en && hit(wa_q, `OSA_RUN_INV_OFF)) begin
			run_inv_q <= hwdata[`OSA_INV_BIT];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			step_sel_q <= `OSA_STEP_SEL_DEF;
		end else if (restore) begin
			step_sel_q <= `OSA_STEP_SEL_DEF;
		end else if (wr_en && hit(wa_q, `OSA_STEP_SEL_OFF)) begin
			step_sel_q <= hwdata[`OSA_SEL_MSB:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			step_inv_q <= `OSA_INV_DEF;
		end else if (restore) begin
			step_inv_q <= `OSA_INV_DEF;
		end else if (wr_en && hit(wa_q, `OSA_STEP_INV_OFF)) begin
			step_inv_q <= hwdata[`OSA_INV_BIT];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			end_sel_q <= `OSA_END_SEL_DEF;
		end else if (restore) begin
			end_sel_q <= `OSA_END_SEL_DEF;
		end else if (wr_en && hit(wa_q, `OSA_END_SEL_OFF)) begin
			end_sel_q <= hwdata[`OSA_SEL_MSB:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			end_inv_q <= `OSA_INV_DEF;
		end else if (restore) begin
			end_inv_q <= `OSA_INV_DEF;
		end else if (wr_en && hit(wa_q, `OSA_END_INV_OFF)) begin
			end_inv_q <= hwdata[`OSA_INV_BIT];
		end
	end

	// general output levels for ports no indicator claims
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			genout_q <= `OSA_GENOUT_DEF;
		end else if (wr_en && hit(wa_q, `OSA_GENOUT_OFF)) begin
			genout_q <= hwdata[7:0];
		end
	end

	// ----------------------------------------
	// status word
	// ----------------------------------------
	// motion_start lets software see motion begin before moving rises
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stat_q <= 6'h00;
		end else begin
			stat_q[`OSA_ST_RUN] <= running;
			stat_q[`OSA_ST_MOVE] <= moving | motion_start;
			stat_q[`OSA_ST_END] <= end_indicator;
			stat_q[`OSA_ST_STEP] <= step_sync_signal;
			stat_q[`OSA_ST_HOME] <= home_indicator;
			stat_q[`OSA_ST_BRAKE] <= brake_control_output;
		end
	end
	assign output_status_word = stat_q;

	// ----------------------------------------
	// port routing
	// ----------------------------------------
	osa_port_t port_q;
	assign gen_out = port_q;

	for (genvar p = 0; p < 8; p++) begin : g_port
		// priority order follows status bit index: run, end, step
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				port_q[p] <= 1'b0;
			end else if (run_sel_q == 3'(p)) begin
				port_q[p] <= running ^ run_inv_q;
			end else if (end_sel_q == 3'(p)) begin
				port_q[p] <= end_indicator ^ end_inv_q;
			end else if (step_sel_q == 3'(p)) begin
				port_q[p] <= step_sync_signal ^ step_inv_q;
			end else begin
				port_q[p] <= genout_q[p];
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_run_route: assert property (
		##1 gen_out[$past(run_sel_q)] == $past(running ^ run_inv_q))
		else $error("run indicator not on its port");

	a_run_invert: assert property (
		wr_en && hit(wa_q, `OSA_RUN_INV_OFF) |=> run_inv_q == $past(hwdata[0])
			##1 gen_out[$past(run_sel_q)] == ($past(running) ^ $past(hwdata[0], 2)))
		else $error("run invert not applied");

	a_restore_def: assert property (
		restore |=> run_sel_q == `OSA_RUN_SEL_DEF && step_sel_q == `OSA_STEP_SEL_DEF
			&& !run_inv_q && !step_inv_q)
		else $error("defaults not restored");

	a_alarm_clear: assert property (
		alarm_clear_input || alarm_clear_command |=> end_sel_q == `OSA_END_SEL_DEF && !end_inv_q)
		else $error("alarm clear did not restore end assignment");

	a_status_word: assert property (
		##1 {stat_q[5:2], stat_q[0]} == $past({brake_control_output, home_indicator,
			step_sync_signal, end_indicator, running}))
		else $error("status word mismatch");

	a_status_read: assert property (
		addr_ok && !hwrite && hit(haddr[7:0], `OSA_STATUS_OFF) |=> hrdata == {26'h0, $past(stat_q)})
		else $error("status read wrong");

	a_moving_start: assert property (
		motion_start |=> output_status_word[`OSA_ST_MOVE])
		else $error("moving bit missed motion start");

	a_step_route: assert property (
		step_sel_q != run_sel_q && step_sel_q != end_sel_q |=>
			gen_out[$past(step_sel_q)] == $past(step_sync_signal ^ step_inv_q))
		else $error("step sync not on its port");

	a_end_route: assert property (
		end_sel_q != run_sel_q |=> gen_out[$past(end_sel_q)] == $past(end_indicator ^ end_inv_q))
		else $error("end indicator not on its port");

	a_step_sel_wr: assert property (
		wr_en && hit(wa_q, `OSA_STEP_SEL_OFF) |=> step_sel_q == $past(hwdata[2:0]))
		else $error("step select not stored");

	a_conflict_prio: assert property (
		step_sel_q == run_sel_q |=> gen_out[$past(run_sel_q)] == $past(running ^ run_inv_q))
		else $error("conflict priority wrong");

	c_restore_after_wr: cover property (wr_en ##1 restore);
	c_run_inverted: cover property (run_inv_q && running);
	c_conflict: cover property (step_sel_q == run_sel_q && step_sync_signal != running);
	c_status_read: cover property (addr_ok && !hwrite && hit(haddr[7:0], `OSA_STATUS_OFF));

endmodule : osa_top

// [tb/osa_ext_model.sv]
// Purpose: external equipment wired to the general output ports
// Assumes: ports are plain push-pull levels with no pull resistors
// Notes: records levels only; all judgement stays in the bench
`timescale 1ns/10ps
module osa_ext_model (
	input wire logic clk,
	input wire logic rstn,
	input wire osa_pkg::osa_port_t gen_out,
	output osa_pkg::osa_port_t seen_q
);
	import osa_pkg::*;
	// latched once a clock, as a slow input card would see the ports
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) seen_q <= 8'h00;
		else seen_q <= gen_out;
	end
endmodule : osa_ext_model

// [tb/output_signal_assignment_tb_top.sv]
// Purpose: self-checking bench for osa_top
// Assumes: zero-wait AHB-Lite slave, registered gen_out and status
// Notes: expectations come from default routing and port priority
`timescale 1ns/10ps
`include "osa_params.svh"
module output_signal_assignment_tb_top;
	import osa_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [5:0] ind = 6'h00;
	logic mstart = 1'b0;
	logic [3:0] rpulse = 4'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [31:0] rd;
	osa_port_t gen_out;
	osa_port_t seen;
	osa_stat_t stat;
	int err_total = 0;
	int check_count = 0;
	always #4 clk = ~clk;
	osa_top dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .running(ind[0]),
		.moving(ind[1]), .motion_start(mstart), .end_indicator(ind[2]),
		.step_sync_signal(ind[3]), .home_indicator(ind[4]), .brake_control_output(ind[5]),
		.run_command(rpulse[0]), .start_input(rpulse[1]), .alarm_clear_command(rpulse[2]),
		.alarm_clear_input(rpulse[3]), .gen_out(gen_out), .output_status_word(stat));
	osa_ext_model ext (.clk(clk), .rstn(rstn), .gen_out(gen_out), .seen_q(seen));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one single transfer; waits on hready in both phases, no fixed latency assumed
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : xfer
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	task automatic drive(input logic [5:0] v);
		@(posedge clk);
		ind <= v;
		settle();
	endtask : drive
	task automatic pulse(input int k);
		@(posedge clk);
		rpulse[k] <= 1'b1;
		@(posedge clk);
		rpulse <= 4'h0;
	endtask : pulse
	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		#400000;
		err_total++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		drive(6'h0D);
		chk("default routing", 32'h07, gen_out);
		chk("status word", 32'h0D, stat);
		chk("response", 32'h0, hresp);
		chk("ready", 32'h1, hreadyout);
		drive(6'h01);
		for (int i = 0; i < 8; i++) begin
			xfer(1'b1, `OSA_RUN_SEL_OFF, i);
			settle();
			chk("run port", 32'h1 << i, gen_out);
		end
		// select written first, then invert
		xfer(1'b1, `OSA_RUN_INV_OFF, 32'h1);
		drive(6'h00);
		chk("run inverted", 32'h80, gen_out);
		chk("far side level", 32'h80, seen);
		xfer(1'b1, `OSA_GENOUT_OFF, 32'h0F);
		settle();
		chk("unclaimed ports", 32'h89, gen_out);
		xfer(1'b0, `OSA_GENOUT_OFF, 32'h0);
		chk("genout read", 32'h0F, rd);
		xfer(1'b0, `OSA_RUN_SEL_OFF, 32'h0);
		chk("write-only read", 32'h0, rd);
		xfer(1'b0, 8'h40, 32'h0);
		chk("unmapped read", 32'h0, rd);
		for (int k = 0; k < 4; k++) begin
			xfer(1'b1, `OSA_RUN_SEL_OFF, 32'h5);
			pulse(k);
			// running low: a stale select 5 or stale invert would light port 0 or 5
			drive(6'h00);
			chk("restored routing", 32'h08, gen_out);
		end
		xfer(1'b1, `OSA_GENOUT_OFF, 32'h0);
		drive(6'h08);
		for (int i = 0; i < 8; i++) begin
			xfer(1'b1, `OSA_STEP_SEL_OFF, i);
			settle();
			chk("step port", (i == 0 || i == 2) ? 32'h0 : 32'h1 << i, gen_out);
		end
		xfer(1'b1, `OSA_STEP_INV_OFF, 32'h1);
		drive(6'h00);
		chk("step inverted", 32'h80, gen_out);
		drive(6'h04);
		for (int i = 0; i < 8; i++) begin
			xfer(1'b1, `OSA_END_SEL_OFF, i);
			settle();
			chk("end port", (i == 0) ? 32'h80 : (32'h1 << i) | 32'h80, gen_out);
		end
		// power cycle mid-run; indicators stay low across the release edge
		drive(6'h00);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		drive(6'h0D);
		chk("power-on defaults", 32'h07, gen_out);
		for (int b = 0; b < 7; b++) begin
			drive((b == 6) ? 6'h3F : 6'h01 << b);
			xfer(1'b0, `OSA_STATUS_OFF, 32'h0);
			chk("status read", (b == 6) ? 32'h3F : 32'h1 << b, rd);
		end
		drive(6'h00);
		@(posedge clk);
		mstart <= 1'b1;
		@(posedge clk);
		mstart <= 1'b0;
		#1;
		chk("moving on start", 32'h02, stat);
		give_verdict();
	end
endmodule : output_signal_assignment_tb_top
